//--- inc/mic_path_pkg.sv
/*
 * Shared constants and types for the microphone input path control block:
 * register offsets, field positions, reset values, gain decoding steps and
 * the packed control word that drives the analogue front end.
 * Assumes a 7-bit register address and 9-bit register data, as carried by
 * the chip's control interface decoder.
 */
package mic_path_pkg;

    localparam int REG_ADDR_W = 7;
    localparam int REG_DATA_W = 9;
    localparam int REG_COUNT  = 6;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets and table indices

    localparam logic [REG_ADDR_W-1:0] OFS_POWER_CONTROL_ONE     = 7'h01;
    localparam logic [REG_ADDR_W-1:0] OFS_POWER_CONTROL_TWO     = 7'h02;
    localparam logic [REG_ADDR_W-1:0] OFS_LEVEL_CONTROL_ONE     = 7'h20;
    localparam logic [REG_ADDR_W-1:0] OFS_INPUT_ROUTING_CONTROL = 7'h2C;
    localparam logic [REG_ADDR_W-1:0] OFS_INPUT_AMP_GAIN_CONTROL = 7'h2D;
    localparam logic [REG_ADDR_W-1:0] OFS_BOOST_STAGE_CONTROL   = 7'h2F;

    localparam int IDX_PWR1  = 0;
    localparam int IDX_PWR2  = 1;
    localparam int IDX_LVL1  = 2;
    localparam int IDX_ROUTE = 3;
    localparam int IDX_GAIN  = 4;
    localparam int IDX_BOOST = 5;

    ////////////////////////////////////////////////////////////////////////////
    // reset values

    localparam logic [REG_DATA_W-1:0] RST_POWER_CONTROL_ONE      = 9'h000;
    localparam logic [REG_DATA_W-1:0] RST_POWER_CONTROL_TWO      = 9'h000;
    localparam logic [REG_DATA_W-1:0] RST_LEVEL_CONTROL_ONE      = 9'h000;
    localparam logic [REG_DATA_W-1:0] RST_INPUT_ROUTING_CONTROL  = 9'h002;
    localparam logic [REG_DATA_W-1:0] RST_INPUT_AMP_GAIN_CONTROL = 9'h050;
    localparam logic [REG_DATA_W-1:0] RST_BOOST_STAGE_CONTROL    = 9'h000;

    localparam logic [REG_ADDR_W-1:0] REG_OFS [REG_COUNT] = '{
        OFS_POWER_CONTROL_ONE, OFS_POWER_CONTROL_TWO, OFS_LEVEL_CONTROL_ONE,
        OFS_INPUT_ROUTING_CONTROL, OFS_INPUT_AMP_GAIN_CONTROL, OFS_BOOST_STAGE_CONTROL};
    localparam logic [REG_DATA_W-1:0] REG_RST [REG_COUNT] = '{
        RST_POWER_CONTROL_ONE, RST_POWER_CONTROL_TWO, RST_LEVEL_CONTROL_ONE,
        RST_INPUT_ROUTING_CONTROL, RST_INPUT_AMP_GAIN_CONTROL, RST_BOOST_STAGE_CONTROL};

    ////////////////////////////////////////////////////////////////////////////
    // field positions

    localparam int POS_BIAS_OUTPUT_POWER     = 4;  // power_control_one
    localparam int POS_SECONDARY_AMP_POWER   = 6;  // power_control_one
    localparam int POS_INPUT_AMP_POWER       = 2;  // power_control_two
    localparam int POS_MIXER_STAGE_POWER     = 4;  // power_control_two
    localparam int POS_AUTO_LEVEL_SELECT     = 8;  // level_control_one
    localparam int POS_POSITIVE_PIN_ROUTE    = 0;  // input_routing_control
    localparam int POS_SECONDARY_AMP_CONFIG  = 3;  // input_routing_control
    localparam int POS_BIAS_LEVEL_SELECT     = 8;  // input_routing_control
    localparam int POS_GAIN_CODE_LSB         = 0;  // input_amp_gain_control
    localparam int POS_INPUT_AMP_SILENCE     = 6;  // input_amp_gain_control
    localparam int POS_GAIN_ZERO_CROSS       = 7;  // input_amp_gain_control
    localparam int POS_SECONDARY_GAIN_LSB    = 0;  // boost_stage_control
    localparam int POS_POSITIVE_GAIN_LSB     = 4;  // boost_stage_control
    localparam int POS_AMP_TO_MIXER_20DB     = 8;  // boost_stage_control

    localparam int GAIN_CODE_W  = 6;
    localparam int MIX_CODE_W   = 3;

    ////////////////////////////////////////////////////////////////////////////
    // gain decoding: amplifier in quarter dB, mixer paths in whole dB

    localparam int AMP_MIN_QDB  = -48;  // -12 dB at code 000000
    localparam int AMP_STEP_QDB = 3;    // 0.75 dB per code
    localparam int MIX_MIN_DB   = -12;  // at code 001
    localparam int MIX_STEP_DB  = 3;

    typedef struct packed {
        logic              input_amp_power;
        logic              positive_pin_route;
        logic [5:0]        input_amp_gain_code;
        logic signed [8:0] input_amp_gain_qdb;
        logic              input_amp_silence;
        logic              amp_mixer_link;
        logic              amp_to_mixer_20db;
        logic              secondary_amp_power;
        logic              secondary_amp_config;
        logic              input_resistor_bypass_switch;
        logic              mixer_stage_power;
        logic              secondary_link;
        logic signed [5:0] secondary_to_mixer_gain_db;
        logic              positive_link;
        logic signed [5:0] positive_pin_to_mixer_gain_db;
        logic              bias_output_power;
        logic              bias_level_select;
        logic              bias_high_z;
    } analog_ctrl_t;

endpackage

//--- design/ctrl_reg.sv
/*
 * One writable control register with a reset value and a write strobe.
 * Assumes write strobe and data come from logic on the same clock.
 */
module ctrl_reg #(
    parameter int               WIDTH     = 9,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             ref_clk,  // system clock
    input  wire logic             reset_n,  // synchronous reset, active low
    input  wire logic             ce,       // clock enable
    input  wire logic             wr_en,    // write strobe
    input  wire logic [WIDTH-1:0] wr_data,  // write data
    output logic      [WIDTH-1:0] value     // stored value
);

    if (WIDTH < 1) begin : g_bad_width
        $error("ctrl_reg width must be at least one bit");
    end

    logic [WIDTH-1:0] value_q;
    logic [WIDTH-1:0] value_d;

    assign value_d = wr_en ? wr_data : value_q;
    assign value   = value_q;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            value_q <= RESET_VAL;
        end else if (ce) begin
            value_q <= value_d;
        end
    end

endmodule

//--- design/zero_cross_sync.sv
/*
 * Brings the analogue sign comparator into the clock domain and flags a
 * zero crossing as a one-cycle pulse on every change of sign.
 * Assumes the comparator output is asynchronous to ref_clk.
 */
module zero_cross_sync (
    input  wire logic ref_clk,    // system clock
    input  wire logic reset_n,    // synchronous reset, active low
    input  wire logic ce,         // clock enable
    input  wire logic sign_pin,   // asynchronous signal sign
    output logic      crossing    // one-cycle pulse on sign change
);

    logic meta_q;
    logic sync_q;
    logic last_q;

    // edge taken between second and third stage only
    assign crossing = ce && (sync_q != last_q);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else if (ce) begin
            meta_q <= sign_pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

endmodule

//--- design/mic_input_path_control.sv
/*
 * Control registers of the microphone input front end: input amplifier
 * gain with zero-cross timed update, mute, manual or automatic level
 * control, secondary amplifier power and mode, mixer stage gains and power,
 * bias output power and level. Drives a registered control word to the
 * analogue section and offers register readback.
 * Assumes the control interface decoder writes and reads on ref_clk, the
 * level loop supplies its gain code on ref_clk, and the sign comparator is
 * asynchronous.
 */
// Functional notes
// R1: gain code is linear, -12 dB at zero, 0.75 dB steps, resets to 0 dB code.
// R2: one gain field serves negative pin, secondary amp, routed positive pin.
// R3: software leaves the manual gain field alone while the level loop runs.
// R4: select bit 8 hands gain to the level loop when set, resets clear.
// R5: zero-cross bit 7 clear applies at once; set applies at next crossing.
// R6: silence bit 6 resets high, mutes amplifier and cuts mixer link.
// R7: power one bit 6 powers the secondary amplifier, resets off.
// R8: secondary mode bit 3 clear is inverting buffer, set bypasses input resistor.
// R9: boost bit 8 adds 20 dB to amplifier path in mixer, resets clear.
// R10: secondary-to-mixer code zero disconnects; others -12 to +6 dB, 3 dB steps.
// R11: positive-pin-to-mixer code zero disconnects; 001 is -12 dB, 3 dB steps.
// R12: software clears positive pin route before using direct mixer path.
// R13: power two bit 4 powers the mixer stage, resets off.
// R14: routing bit 8 selects bias 0.9 or 0.65 of supply, resets clear.
// R15: power one bit 4 enables bias output, else high impedance; resets off.
// R16: mixer sums amplifier, secondary amp and positive pin, each own gain.
// R17: routing bit 0 ties amplifier plus input to positive pin, else midrail.
// R18: power two bit 2 enables the input amplifier, resets off.
// R19: all control registers nine bits, writable, reset to defaults, hold.
module mic_input_path_control (
    input  wire logic                               ref_clk,        // system clock, 200 MHz
    input  wire logic                               reset_n,        // synchronous reset, active low
    input  wire logic                               ce,             // clock enable, freezes state
    input  wire logic                               reg_wr_en,      // register write strobe
    input  wire logic [mic_path_pkg::REG_ADDR_W-1:0] reg_wr_addr,   // write address
    input  wire logic [mic_path_pkg::REG_DATA_W-1:0] reg_wr_data,   // write data
    input  wire logic [mic_path_pkg::REG_ADDR_W-1:0] reg_rd_addr,   // read address
    output logic      [mic_path_pkg::REG_DATA_W-1:0] reg_rd_data,   // read data, one cycle late
    input  wire logic                               sign_pin,       // async signal sign comparator
    input  wire logic [5:0]                         auto_gain_code, // gain from level loop
    output logic                                    gain_pending,   // zero-cross update waiting
    output mic_path_pkg::analog_ctrl_t              ctrl            // analogue control word
);
    import mic_path_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic [REG_COUNT-1:0]  wr_sel;
    logic [REG_DATA_W-1:0] reg_val [REG_COUNT];

    for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
        assign wr_sel[i] = ce && reg_wr_en && (reg_wr_addr == REG_OFS[i]);
        ctrl_reg #(
            .WIDTH     (REG_DATA_W),
            .RESET_VAL (REG_RST[i])
        ) u_reg (
            .ref_clk (ref_clk),
            .reset_n (reset_n),
            .ce      (ce),
            .wr_en   (wr_sel[i]),  // R19
            .wr_data (reg_wr_data),
            .value   (reg_val[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // field extraction

    wire                   f_bias_power   = reg_val[IDX_PWR1][POS_BIAS_OUTPUT_POWER];
    wire                   f_sec_power    = reg_val[IDX_PWR1][POS_SECONDARY_AMP_POWER];
    wire                   f_amp_power    = reg_val[IDX_PWR2][POS_INPUT_AMP_POWER];
    wire                   f_mixer_power  = reg_val[IDX_PWR2][POS_MIXER_STAGE_POWER];
    wire                   f_auto_select  = reg_val[IDX_LVL1][POS_AUTO_LEVEL_SELECT];
    wire                   f_pos_route    = reg_val[IDX_ROUTE][POS_POSITIVE_PIN_ROUTE];
    wire                   f_sec_config   = reg_val[IDX_ROUTE][POS_SECONDARY_AMP_CONFIG];
    wire                   f_bias_level   = reg_val[IDX_ROUTE][POS_BIAS_LEVEL_SELECT];
    wire [GAIN_CODE_W-1:0] f_gain_code    = reg_val[IDX_GAIN][POS_GAIN_CODE_LSB +: GAIN_CODE_W];
    wire                   f_silence      = reg_val[IDX_GAIN][POS_INPUT_AMP_SILENCE];
    wire                   f_zero_cross   = reg_val[IDX_GAIN][POS_GAIN_ZERO_CROSS];
    wire [MIX_CODE_W-1:0]  f_sec_mix_code = reg_val[IDX_BOOST][POS_SECONDARY_GAIN_LSB +: MIX_CODE_W];
    wire [MIX_CODE_W-1:0]  f_pos_mix_code = reg_val[IDX_BOOST][POS_POSITIVE_GAIN_LSB +: MIX_CODE_W];
    wire                   f_boost_20db   = reg_val[IDX_BOOST][POS_AMP_TO_MIXER_20DB];

    ////////////////////////////////////////////////////////////////////////////
    // gain decoding

    function automatic logic signed [8:0] amp_qdb(input logic [GAIN_CODE_W-1:0] code);
        amp_qdb = 9'(AMP_MIN_QDB + AMP_STEP_QDB * int'(code));  // R1
    endfunction

    function automatic logic signed [5:0] mix_db(input logic [MIX_CODE_W-1:0] code);
        mix_db = (code == '0) ? 6'sh00 : 6'(MIX_MIN_DB + MIX_STEP_DB * (int'(code) - 1));  // R10 R11
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // zero-cross timed gain update

    logic                   crossing;
    logic                   pending_q;
    logic                   pending_d;
    logic [GAIN_CODE_W-1:0] applied_q;
    logic [GAIN_CODE_W-1:0] applied_d;
    logic [GAIN_CODE_W-1:0] eff_code;

    zero_cross_sync u_zc (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .sign_pin (sign_pin),
        .crossing (crossing)
    );

    wire gain_write  = wr_sel[IDX_GAIN];
    wire arm_write   = gain_write && reg_wr_data[POS_GAIN_ZERO_CROSS];
    wire apply_cross = pending_q && crossing && !gain_write;

    // a write setting bit 7 in the crossing cycle re-arms and waits for the next crossing
    assign pending_d = arm_write ? 1'b1 :
                       (apply_cross || !f_zero_cross) ? 1'b0 : pending_q;  // R5
    assign applied_d = (!f_zero_cross || apply_cross) ? f_gain_code : applied_q;  // R5 R1

    // level loop owns the gain when selected
    assign eff_code = f_auto_select ? auto_gain_code : applied_q;  // R4 R3

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pending_q <= 1'b0;
            applied_q <= RST_INPUT_AMP_GAIN_CONTROL[POS_GAIN_CODE_LSB +: GAIN_CODE_W];
        end else if (ce) begin
            pending_q <= pending_d;
            applied_q <= applied_d;
        end
    end

    assign gain_pending = pending_q;

    ////////////////////////////////////////////////////////////////////////////
    // analogue control word

    analog_ctrl_t ctrl_d;
    analog_ctrl_t ctrl_q;

    // reset word matches the register defaults, never an all-zero word
    localparam logic [GAIN_CODE_W-1:0] RST_CODE = RST_INPUT_AMP_GAIN_CONTROL[POS_GAIN_CODE_LSB +: GAIN_CODE_W];
    localparam analog_ctrl_t CTRL_RST = '{
        input_amp_gain_code: RST_CODE,
        input_amp_gain_qdb:  amp_qdb(RST_CODE),
        input_amp_silence:   RST_INPUT_AMP_GAIN_CONTROL[POS_INPUT_AMP_SILENCE],
        bias_high_z:         !RST_POWER_CONTROL_ONE[POS_BIAS_OUTPUT_POWER],
        default:             '0};

    always_comb begin
        ctrl_d                               = '0;
        ctrl_d.input_amp_power               = f_amp_power;                  // R18
        ctrl_d.positive_pin_route            = f_pos_route;                  // R17 R2
        ctrl_d.input_amp_gain_code           = eff_code;                     // R2
        ctrl_d.input_amp_gain_qdb            = amp_qdb(eff_code);            // R1
        ctrl_d.input_amp_silence             = f_silence;                    // R6
        ctrl_d.amp_mixer_link                = !f_silence;                   // R6 R16
        ctrl_d.amp_to_mixer_20db             = f_boost_20db;                 // R9
        ctrl_d.secondary_amp_power           = f_sec_power;                  // R7
        ctrl_d.secondary_amp_config          = f_sec_config;                 // R8
        ctrl_d.input_resistor_bypass_switch  = f_sec_config;                 // R8
        ctrl_d.mixer_stage_power             = f_mixer_power;                // R13
        ctrl_d.secondary_link                = (f_sec_mix_code != '0);       // R10 R16
        ctrl_d.secondary_to_mixer_gain_db    = mix_db(f_sec_mix_code);       // R10
        ctrl_d.positive_link                 = (f_pos_mix_code != '0);       // R11 R16
        ctrl_d.positive_pin_to_mixer_gain_db = mix_db(f_pos_mix_code);       // R11
        ctrl_d.bias_output_power             = f_bias_power;                 // R15
        ctrl_d.bias_level_select             = f_bias_level;                 // R14
        ctrl_d.bias_high_z                   = !f_bias_power;                // R15
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RST;  // R6 R15
        end else if (ce) begin
            ctrl_q <= ctrl_d;
        end
    end

    assign ctrl = ctrl_q;

    ////////////////////////////////////////////////////////////////////////////
    // register readback, unmapped addresses read zero

    logic [REG_DATA_W-1:0] rd_d;
    logic [REG_DATA_W-1:0] rd_q;

    always_comb begin
        rd_d = '0;
        for (int i = 0; i < REG_COUNT; i++) begin
            if (reg_rd_addr == REG_OFS[i]) begin
                rd_d = reg_val[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rd_q <= '0;
        end else if (ce) begin
            rd_q <= rd_d;
        end
    end

    assign reg_rd_data = rd_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n || !ce);

    sequence armed_s;
        arm_write;
    endsequence

    sequence cross_hit_s;
        pending_q && crossing && !gain_write;
    endsequence

    gain_reset_a: assert property ( // R1
        !$past(reset_n) |-> (applied_q == 6'h10) && f_silence && !f_auto_select && !pending_q)
        else $error("gain block not at reset defaults");

    gain_decode_a: assert property ( // R1
        ctrl.input_amp_gain_qdb == 9'(AMP_MIN_QDB + AMP_STEP_QDB * int'(ctrl.input_amp_gain_code)))
        else $error("amplifier gain decode wrong");

    gain_select_a: assert property ( // R4
        1'b1 |=> ctrl.input_amp_gain_code == ($past(f_auto_select) ? $past(auto_gain_code) : $past(applied_q)))
        else $error("gain source selection wrong");

    direct_update_a: assert property ( // R5
        gain_write && !reg_wr_data[POS_GAIN_ZERO_CROSS] ##1 ce
        |=> applied_q == $past(f_gain_code))
        else $error("direct gain update not applied");

    cross_arm_a: assert property ( // R5
        armed_s |=> pending_q)
        else $error("zero-cross update not armed");

    cross_hold_a: assert property ( // R5
        pending_q && !crossing && f_zero_cross |=> $stable(applied_q))
        else $error("gain changed before zero crossing");

    cross_apply_a: assert property ( // R5
        cross_hit_s |=> (applied_q == $past(f_gain_code)) && !pending_q)
        else $error("gain not applied at zero crossing");

    silence_link_a: assert property ( // R6
        ctrl.amp_mixer_link == !ctrl.input_amp_silence)
        else $error("muted amplifier still linked to mixer");

    mixer_paths_a: assert property ( // R10
        ctrl.secondary_link == ($past(f_sec_mix_code) != 3'h0)
        && ctrl.positive_link == ($past(f_pos_mix_code) != 3'h0))
        else $error("mixer path connect wrong");

    mixer_gain_a: assert property ( // R11
        ctrl.positive_link |-> ctrl.positive_pin_to_mixer_gain_db
        == 6'(MIX_MIN_DB + MIX_STEP_DB * (int'($past(f_pos_mix_code)) - 1)))
        else $error("positive pin mixer gain wrong");

    bias_out_a: assert property ( // R15
        ctrl.bias_high_z == !ctrl.bias_output_power)
        else $error("bias output enable and high impedance disagree");

    power_bits_a: assert property ( // R13
        1'b1 |=> ctrl.mixer_stage_power == $past(f_mixer_power)
        && ctrl.secondary_amp_power == $past(f_sec_power)
        && ctrl.input_amp_power == $past(f_amp_power))
        else $error("power enable not reflected");

    readback_a: assert property ( // R19
        reg_rd_addr == OFS_INPUT_AMP_GAIN_CONTROL |=> reg_rd_data == $past(reg_val[IDX_GAIN]))
        else $error("readback of gain register wrong");

    pending_drop_a: assert property ( // R5
        pending_q && !f_zero_cross && !arm_write
        |=> !pending_q && applied_q == $past(f_gain_code))
        else $error("cancelled update still waiting");

    route_bias_a: assert property ( // R17 R14
        1'b1 |=> ctrl.positive_pin_route == $past(f_pos_route)
        && ctrl.bias_level_select == $past(f_bias_level))
        else $error("routing or bias level wrong");

    aux_mode_a: assert property ( // R8
        1'b1 |=> ctrl.secondary_amp_config == $past(f_sec_config)
        && ctrl.input_resistor_bypass_switch == $past(f_sec_config))
        else $error("secondary mode wrong");

    reset_word_a: assert property ( // R6
        !$past(reset_n) |-> ctrl == CTRL_RST)
        else $error("control word not at defaults");

endmodule

//--- tb/host_model.sv
/*
 * Host side of the register write port: whole 9-bit words, one strobe each.
 * Assumes the block samples the write port on the rising edge of ref_clk.
 */
module host_model (
    input  wire logic                           ref_clk,     // system clock
    output logic                                reg_wr_en,   // write strobe
    output logic [mic_path_pkg::REG_ADDR_W-1:0] reg_wr_addr, // write address
    output logic [mic_path_pkg::REG_DATA_W-1:0] reg_wr_data  // write data
);
    timeunit 1ns;
    timeprecision 1ps;
    import mic_path_pkg::*;
    initial begin
        reg_wr_en   = 1'b0;
        reg_wr_addr = 7'h00;
        reg_wr_data = 9'h000;
    end
    // released lines show the inverse, so stale values never pass for valid
    task automatic write(input logic [REG_ADDR_W-1:0] a, input logic [REG_DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_wr_en   <= 1'b1;
        reg_wr_addr <= a;
        reg_wr_data <= d;
        @(posedge ref_clk);
        reg_wr_en   <= 1'b0;
        reg_wr_addr <= ~a;
        reg_wr_data <= ~d;
    endtask
endmodule

//--- tb/testbench.sv
/*
 * Self-checking bench for the microphone input path control block.
 * Assumes mic_path_pkg and host_model are compiled first.
 */
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mic_path_pkg::*;
    logic                  ref_clk   = 1'b0;
    logic                  reset_n   = 1'b0;
    logic                  ce        = 1'b1;
    logic                  sign_pin  = 1'b0;
    logic                  rd_go     = 1'b0;
    logic                  rd_chk    = 1'b0;
    logic [REG_ADDR_W-1:0] rd_addr   = 7'h00;
    logic [5:0]            auto_code = 6'h00;
    logic [15:0]           seed      = 16'h0018;
    logic [5:0]            codes [4] = '{6'h00, 6'h3F, 6'h01, 6'h2A};
    logic [REG_DATA_W-1:0] pats [2][3] = '{'{9'h050, 9'h014, 9'h10B}, '{9'h1AF, 9'h1EB, 9'h0F4}};
    logic [REG_DATA_W-1:0] rd_data, wr_data, exp_v;
    logic [REG_DATA_W-1:0] exp_q [$];
    logic [REG_ADDR_W-1:0] wr_addr;
    logic                  wr_en, pending, b;
    analog_ctrl_t          ctrl;
    int                    errors = 0;
    int                    check_count = 0;

    always #2.5 ref_clk = ~ref_clk;

    host_model i_host (.ref_clk(ref_clk), .reg_wr_en(wr_en), .reg_wr_addr(wr_addr), .reg_wr_data(wr_data));
    mic_input_path_control i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .reg_wr_en(wr_en),
        .reg_wr_addr(wr_addr), .reg_wr_data(wr_data), .reg_rd_addr(rd_addr), .reg_rd_data(rd_data),
        .sign_pin(sign_pin), .auto_gain_code(auto_code), .gain_pending(pending), .ctrl(ctrl));

    ////////////////////////////////////////////////////////////////////////////
    // read results appear one edge after the request is launched and are checked on the second
    always @(posedge ref_clk) begin
        rd_chk <= rd_go;
        if (rd_chk) begin
            exp_v = exp_q.pop_front();
            `CHK(rd_data, exp_v)
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic signed [5:0] mix_db(input logic [2:0] c);
        return (c == 3'h0) ? 6'h00 : 6'(MIX_MIN_DB + MIX_STEP_DB * (int'(c) - 1));
    endfunction
    task automatic rd(input logic [REG_ADDR_W-1:0] a, input logic [REG_DATA_W-1:0] e);
        @(posedge ref_clk);
        rd_addr <= a;
        rd_go   <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        rd_go <= 1'b0;
    endtask
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic test_done(input string n);
        $display("test %s done", n);
    endtask
    task automatic tally_and_finish();
        repeat (3) @(posedge ref_clk);
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        settle();
        `CHK(ctrl.input_amp_gain_code, 6'h10)
        `CHK(ctrl.input_amp_gain_qdb, 9'h000)
        `CHK(ctrl.input_amp_silence, 1'b1)
        `CHK(ctrl.amp_mixer_link, 1'b0)
        `CHK(ctrl.bias_high_z, 1'b1)
        `CHK(pending, 1'b0)
        for (int i = 0; i < REG_COUNT; i++) rd(REG_OFS[i], REG_RST[i]);
        rd(7'h03, 9'h000);
        @(posedge ref_clk) ce <= 1'b0;
        i_host.write(OFS_BOOST_STAGE_CONTROL, 9'h1FF);
        ce <= 1'b1;
        rd(OFS_BOOST_STAGE_CONTROL, 9'h000);
        for (int i = 0; i < REG_COUNT; i++) begin
            seed = lfsr(seed);
            i_host.write(REG_OFS[i], seed[8:0]);
            rd(REG_OFS[i], seed[8:0]);
        end
        test_done("registers");
        i_host.write(OFS_LEVEL_CONTROL_ONE, 9'h000);
        for (int k = 0; k < 4; k++) begin
            i_host.write(OFS_INPUT_AMP_GAIN_CONTROL, {3'h0, codes[k]});
            settle();
            `CHK(ctrl.input_amp_gain_code, codes[k])
            `CHK(ctrl.input_amp_gain_qdb, 9'(AMP_MIN_QDB + AMP_STEP_QDB * int'(codes[k])))
            `CHK(ctrl.amp_mixer_link, 1'b1)
        end
        test_done("gain");
        i_host.write(OFS_INPUT_ROUTING_CONTROL, 9'h002);
        for (int c = 0; c < 8; c++) begin
            i_host.write(OFS_BOOST_STAGE_CONTROL, {1'(c), 1'b0, 3'(7 - c), 1'b0, 3'(c)});
            settle();
            `CHK(ctrl.amp_to_mixer_20db, 1'(c))
            `CHK(ctrl.secondary_link, 1'(c != 0))
            `CHK(ctrl.secondary_to_mixer_gain_db, mix_db(3'(c)))
            `CHK(ctrl.positive_link, 1'(c != 7))
            `CHK(ctrl.positive_pin_to_mixer_gain_db, mix_db(3'(7 - c)))
        end
        test_done("mixer");
        for (int p = 0; p < 2; p++) begin
            b = (p == 0);
            i_host.write(OFS_POWER_CONTROL_ONE, pats[p][0]);
            i_host.write(OFS_POWER_CONTROL_TWO, pats[p][1]);
            i_host.write(OFS_INPUT_ROUTING_CONTROL, pats[p][2]);
            settle();
            `CHK(ctrl.bias_output_power, b)
            `CHK(ctrl.bias_high_z, !b)
            `CHK(ctrl.secondary_amp_power, b)
            `CHK(ctrl.input_amp_power, b)
            `CHK(ctrl.mixer_stage_power, b)
            `CHK(ctrl.positive_pin_route, b)
            `CHK(ctrl.secondary_amp_config, b)
            `CHK(ctrl.input_resistor_bypass_switch, b)
            `CHK(ctrl.bias_level_select, b)
        end
        test_done("power");
        i_host.write(OFS_INPUT_AMP_GAIN_CONTROL, 9'h0A5);
        settle();
        `CHK(pending, 1'b1)
        `CHK(ctrl.input_amp_gain_code, 6'h2A)
        @(posedge ref_clk) sign_pin <= ~sign_pin;
        for (int i = 0; i < 20 && pending !== 1'b0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (pending !== 1'b0) begin
            errors++;
            tally_and_finish();
        end
        settle();
        `CHK(ctrl.input_amp_gain_code, 6'h25)
        test_done("zero cross");
        seed = lfsr(seed);
        @(posedge ref_clk) auto_code <= seed[5:0];
        i_host.write(OFS_LEVEL_CONTROL_ONE, 9'h100);
        settle();
        `CHK(ctrl.input_amp_gain_code, seed[5:0])
        rd(OFS_INPUT_AMP_GAIN_CONTROL, 9'h0A5);
        i_host.write(OFS_LEVEL_CONTROL_ONE, 9'h000);
        settle();
        settle();
        `CHK(ctrl.input_amp_gain_code, 6'h25)
        test_done("auto level");
        tally_and_finish();
    end
endmodule
